// ==== design/emb_defines.svh ====
// Constants for the expansion bus and MAC arbiter: offsets, fields, resets and timing.
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define EMB_NUM_REP 3
`define EMB_CNT_W 7
`define EMB_CNT_TERM 7'h60
`define EMB_CNT_ZERO 7'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EMB_CLK_NS 20
`define EMB_ARB_RES_NS 100
`define EMB_ARB_RES_CYC ((`EMB_ARB_RES_NS) / (`EMB_CLK_NS))

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define EMB_ADDR_CTRL 32'h0000_0000
`define EMB_ADDR_STAT 32'h0000_0004
`define EMB_CTRL_MASK_RST 3'h7
`define EMB_STAT_GRANT 0
`define EMB_STAT_CLASH 1
`define EMB_STAT_BACKOFF 2
`define EMB_STAT_TXCLASH 3
`define EMB_STAT_CARRIER 4
`define EMB_STAT_CNT_LSB 8
`define EMB_STAT_DONE 15
`define EMB_RESP_OKAY 2'h0
`define EMB_RESP_SLVERR 2'h2

`endif

// ==== design/emb_pkg.sv ====
// Types shared by the expansion bus and MAC arbiter.
package emb_pkg;

    // ------------------------------------------------------------------
    // Register bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } emb_axi_in_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } emb_axi_out_t;

    // ------------------------------------------------------------------
    // Complete state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rst_int;
        logic tx_strobe;
        logic [6:0] cnt;
        logic grant_delayed;
        logic clash_delayed;
        logic mac_send_ask_delayed;
        logic mac_backoff;
        logic tx_clash_state;
        logic min_event_trigger;
        logic mac_side_bit;
        logic mac_rx_strobe_gate;
        logic line_bit;
        logic [2:0] req_mask;
        logic aw_got;
        logic [31:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } emb_state_t;

endpackage

// ==== design/emb_arbiter.sv ====
// Expansion bus arbiter, 7-bit minimum-event counter (terminal count 96) and MAC serial interface.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "emb_defines.svh"

module emb_arbiter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_reset_in,
    input wire logic [`EMB_NUM_REP-1:0] rep_req_n,
    output logic rep_grant_n,
    output logic rep_clash_n,
    input wire logic shared_serial_line_i,
    output logic shared_serial_line_o,
    output logic shared_serial_line_oe,
    input wire logic jam_i,
    output logic jam_o,
    output logic jam_oe,
    input wire logic mac_send_ask,
    input wire logic mac_txd,
    output logic mac_tx_strobe,
    output logic mac_rxd,
    output logic mac_rx_strobe,
    output logic mac_carrier,
    output logic mac_backoff,
    output logic bus_reset,
    input wire emb_pkg::emb_axi_in_t axi_in,
    output emb_pkg::emb_axi_out_t axi_out
);
    import emb_pkg::*;

    emb_state_t st_reg;
    emb_state_t st_next;

    logic [`EMB_NUM_REP-1:0] rep_req;
    logic any_rep;
    logic one_rep;
    logic any_req;
    logic grant;
    logic clash;
    logic done_count;
    logic settled;
    logic drive_en;
    logic wr_fire;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------

    // Pins are active low; masked repeaters are treated as silent.
    assign rep_req = ~rep_req_n & st_reg.req_mask;
    assign any_rep = |rep_req;
    assign one_rep = ($countones(rep_req) == 1);
    assign any_req = any_rep | mac_send_ask;

    // Pure gates, zero clocks from request to grant, well inside 100 ns.
    always_comb begin
        grant = (one_rep & ~mac_send_ask) | (~any_rep & mac_send_ask);
        // Keeps the MAC granted through its last bit after it drops its ask.
        if (~any_rep & st_reg.mac_send_ask_delayed & st_reg.grant_delayed & ~st_reg.mac_backoff) begin
            grant = 1'b1;
        end
        clash = ~grant & any_req;
    end

    assign rep_grant_n = ~grant;
    assign rep_clash_n = ~clash;

    // Terminal count is a fixed decode, not a compare against a register.
    assign done_count = st_reg.cnt[6] & st_reg.cnt[5] & ~(|st_reg.cnt[4:0]);
    assign settled = grant & st_reg.grant_delayed;

    // ------------------------------------------------------------------
    // MAC and expansion line interface
    // ------------------------------------------------------------------

    // The line is released unless the MAC has a settled grant of its own.
    assign drive_en = grant & st_reg.grant_delayed & st_reg.mac_send_ask_delayed;
    assign shared_serial_line_oe = drive_en;
    assign jam_oe = drive_en;
    assign shared_serial_line_o = st_reg.line_bit | st_reg.mac_backoff;
    assign jam_o = st_reg.mac_backoff;

    assign mac_carrier = (settled & ~jam_i & ~st_reg.mac_backoff) | st_reg.mac_rx_strobe_gate;
    // Gated clock: the enable only changes on the rising edge while aclk is high,
    // so the strobe cannot glitch during the low half.
    assign mac_rx_strobe = st_reg.mac_rx_strobe_gate & ~aclk;
    assign mac_rxd = st_reg.mac_side_bit;
    assign mac_tx_strobe = st_reg.tx_strobe;
    assign mac_backoff = st_reg.mac_backoff;
    assign bus_reset = st_reg.rst_int;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------

    assign axi_out.awready = ~st_reg.aw_got & ~st_reg.bvalid;
    assign axi_out.wready = ~st_reg.w_got & ~st_reg.bvalid;
    assign axi_out.bvalid = st_reg.bvalid;
    assign axi_out.bresp = st_reg.bresp;
    assign axi_out.arready = ~st_reg.rvalid;
    assign axi_out.rvalid = st_reg.rvalid;
    assign axi_out.rdata = st_reg.rdata;
    assign axi_out.rresp = st_reg.rresp;
    assign wr_fire = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;

    // Status snapshot of the block's own live state.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`EMB_STAT_GRANT] = grant;
        status_word[`EMB_STAT_CLASH] = clash;
        status_word[`EMB_STAT_BACKOFF] = st_reg.mac_backoff;
        status_word[`EMB_STAT_TXCLASH] = st_reg.tx_clash_state;
        status_word[`EMB_STAT_CARRIER] = mac_carrier;
        status_word[`EMB_STAT_CNT_LSB +: `EMB_CNT_W] = st_reg.cnt;
        status_word[`EMB_STAT_DONE] = done_count;
        rd_word = 32'h0000_0000;
        if (axi_in.araddr == `EMB_ADDR_CTRL) begin
            rd_word = {29'h0000_0000, st_reg.req_mask};
        end else if (axi_in.araddr == `EMB_ADDR_STAT) begin
            rd_word = status_word;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // All flops share one next-state process so nothing has two drivers.
    always_comb begin
        st_next = st_reg;
        st_next.rst_int = async_reset_in;
        st_next.tx_strobe = ~st_reg.tx_strobe & ~st_reg.rst_int & ~async_reset_in;
        st_next.grant_delayed = grant;
        st_next.clash_delayed = clash;
        st_next.mac_send_ask_delayed = mac_send_ask;

        // Counter steps in the low phase of the bit strobe only.
        if (st_reg.rst_int) begin
            st_next.cnt = `EMB_CNT_TERM;
        end else if (st_reg.min_event_trigger) begin
            st_next.cnt = `EMB_CNT_ZERO;
        end else if (~st_reg.tx_strobe & ~done_count) begin
            st_next.cnt = st_reg.cnt + 7'h01;
        end

        // The trigger is registered, so the counter still reads 96 for one clock after it
        // fires; holding back-off across that clock keeps the MAC off for the full event.
        st_next.mac_backoff = clash | (settled & jam_i) | (st_reg.clash_delayed & grant)
            | ((~done_count | st_reg.min_event_trigger) & st_reg.mac_backoff);
        st_next.tx_clash_state = (settled & jam_i & ~shared_serial_line_i) | clash
            | (st_reg.clash_delayed & grant);
        st_next.min_event_trigger = (grant & ~st_reg.grant_delayed & ~st_reg.mac_backoff)
            | (settled & jam_i & ~shared_serial_line_i & ~st_reg.tx_clash_state)
            | (clash & ~st_reg.tx_clash_state);
        st_next.mac_side_bit = (~mac_send_ask & shared_serial_line_i & settled)
            | (mac_txd & mac_send_ask);
        st_next.mac_rx_strobe_gate = (settled & ~mac_send_ask & ~st_reg.mac_send_ask_delayed
            & ~jam_i) | (grant & mac_send_ask & ~st_reg.mac_backoff);
        // A second stage delays the line one clock so it never moves at the sampling edge.
        st_next.line_bit = st_reg.mac_side_bit;

        // Write address and data are taken in either order.
        if (axi_in.awvalid & axi_out.awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = axi_in.awaddr;
        end
        if (axi_in.wvalid & axi_out.wready) begin
            st_next.w_got = 1'b1;
            st_next.w_data = axi_in.wdata;
            st_next.w_strb = axi_in.wstrb;
        end
        if (wr_fire) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `EMB_RESP_OKAY;
            if (st_reg.aw_addr == `EMB_ADDR_CTRL) begin
                if (st_reg.w_strb[0]) begin
                    st_next.req_mask = st_reg.w_data[2:0];
                end
            end else if (st_reg.aw_addr != `EMB_ADDR_STAT) begin
                st_next.bresp = `EMB_RESP_SLVERR;
            end
        end else if (st_reg.bvalid & axi_in.bready) begin
            st_next.bvalid = 1'b0;
        end
        if (axi_in.arvalid & axi_out.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word;
            st_next.rresp = ((axi_in.araddr == `EMB_ADDR_CTRL) || (axi_in.araddr == `EMB_ADDR_STAT))
                ? `EMB_RESP_OKAY : `EMB_RESP_SLVERR;
        end else if (st_reg.rvalid & axi_in.rready) begin
            st_next.rvalid = 1'b0;
        end

        // Bus reset puts every flop at a constant; internal reset follows next clock.
        if (!aresetn) begin
            st_next = '0;
            st_next.rst_int = 1'b1;
            st_next.cnt = `EMB_CNT_TERM;
            st_next.req_mask = `EMB_CTRL_MASK_RST;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Single clocked process; reset is handled in the next-state logic.
    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    cnt_reset_load_a: assert property (st_reg.rst_int |=> st_reg.cnt == `EMB_CNT_TERM)
        else $error("counter not at 96 after internal reset");
    cnt_retrigger_a: assert property ((st_reg.min_event_trigger && !st_reg.rst_int)
        |=> st_reg.cnt == `EMB_CNT_ZERO)
        else $error("counter not cleared by trigger");
    cnt_step_a: assert property ((!st_reg.rst_int && !st_reg.min_event_trigger
        && !st_reg.tx_strobe && !done_count) |=> st_reg.cnt == $past(st_reg.cnt) + 7'h01)
        else $error("counter failed to advance");
    cnt_hold_done_a: assert property ((done_count && !st_reg.min_event_trigger && !st_reg.rst_int)
        |=> done_count)
        else $error("counter left terminal value untriggered");
    strobe_toggle_a: assert property ((!st_reg.rst_int && !async_reset_in)
        |=> mac_tx_strobe != $past(mac_tx_strobe))
        else $error("transmit strobe did not toggle");
    grant_onehot_a: assert property ((any_rep || mac_send_ask) && !st_reg.mac_send_ask_delayed
        |-> grant == ($countones({rep_req, mac_send_ask}) == 1))
        else $error("grant not one-hot");
    clash_grant_excl_a: assert property (!(grant && clash) && (clash == (any_req && !grant)))
        else $error("clash and grant inconsistent");
    backoff_on_clash_a: assert property (clash |=> mac_backoff [*2])
        else $error("back-off not raised by clash");
    backoff_hold_a: assert property ((mac_backoff && !done_count) |=> mac_backoff)
        else $error("back-off dropped before expiry");
    drive_cond_a: assert property (shared_serial_line_oe |-> (grant && st_reg.grant_delayed
        && st_reg.mac_send_ask_delayed && jam_oe))
        else $error("line driven without settled MAC grant");
    jam_follow_a: assert property (mac_backoff |-> (jam_o && shared_serial_line_o))
        else $error("back-off not forcing line and jam");
    side_bit_tx_a: assert property (mac_send_ask |=> mac_rxd == $past(mac_txd))
        else $error("MAC-side bit did not take transmit data");
    line_hold_a: assert property (##1 shared_serial_line_o == ($past(st_reg.mac_side_bit)
        || mac_backoff))
        else $error("driven line not delayed copy of MAC-side bit");

    grant_copy_a: assert property (1'b1 |=> st_reg.grant_delayed == $past(grant))
        else $error("delayed grant is not last grant");

    ask_copy_a: assert property (1'b1 |=> st_reg.mac_send_ask_delayed == $past(mac_send_ask))
        else $error("delayed MAC ask is not last ask");

    reset_follow_a: assert property (1'b1 |=> bus_reset == $past(async_reset_in))
        else $error("bus reset does not follow board reset");

    strobe_low_rst_a: assert property ((st_reg.rst_int || async_reset_in) |=> !mac_tx_strobe)
        else $error("transmit strobe not low in reset");

    cnt_range_a: assert property (st_reg.cnt <= `EMB_CNT_TERM)
        else $error("counter ran past terminal value");

    done_decode_a: assert property (done_count == (st_reg.cnt == `EMB_CNT_TERM))
        else $error("expiry decode wrong");

    cnt_idle_hold_a: assert property ((!st_reg.rst_int && !st_reg.min_event_trigger
        && st_reg.tx_strobe) |=> $stable(st_reg.cnt))
        else $error("counter moved off its bit phase");

    backoff_trig_hold_a: assert property ((mac_backoff && st_reg.min_event_trigger)
        |=> mac_backoff)
        else $error("back-off dropped while trigger pending");

    backoff_jam_a: assert property ((settled && jam_i) |=> mac_backoff)
        else $error("back-off not raised by settled jam");

    backoff_late_a: assert property ((st_reg.clash_delayed && grant) |=> mac_backoff)
        else $error("back-off not raised by grant after clash");

    txclash_set_a: assert property ((clash || (st_reg.clash_delayed && grant))
        |=> st_reg.tx_clash_state)
        else $error("transmit clash not set by clash");

    txclash_jam_a: assert property ((settled && jam_i && !shared_serial_line_i)
        |=> st_reg.tx_clash_state)
        else $error("transmit clash not set by jam");

    trig_grant_a: assert property ((grant && !st_reg.grant_delayed && !mac_backoff)
        |=> st_reg.min_event_trigger)
        else $error("trigger missed on new grant");

    trig_clash_a: assert property ((clash && !st_reg.tx_clash_state)
        |=> st_reg.min_event_trigger)
        else $error("trigger missed on new clash");

    line_release_a: assert property (!(grant && st_reg.grant_delayed
        && st_reg.mac_send_ask_delayed) |-> (!shared_serial_line_oe && !jam_oe))
        else $error("lines driven without settled MAC grant");

    carrier_grant_a: assert property ((settled && !jam_i && !mac_backoff) |-> mac_carrier)
        else $error("carrier missing on settled grant");

    carrier_gate_a: assert property (st_reg.mac_rx_strobe_gate |-> mac_carrier)
        else $error("carrier missing while receive gate set");

    side_bit_line_a: assert property ((!mac_send_ask && settled)
        |=> mac_rxd == $past(shared_serial_line_i))
        else $error("MAC-side bit did not take shared line");

    gate_loop_a: assert property ((grant && mac_send_ask && !mac_backoff)
        |=> st_reg.mac_rx_strobe_gate)
        else $error("receive gate not set for loopback");

    grant_extend_a: assert property ((!any_rep && st_reg.mac_send_ask_delayed
        && st_reg.grant_delayed && !mac_backoff) |-> grant)
        else $error("grant not extended after MAC ask");

    pin_polarity_a: assert property ((rep_grant_n == !grant) && (rep_clash_n == !clash))
        else $error("grant or clash pin polarity wrong");

endmodule

// ==== tb/emb_rep_model.sv ====
// Behavioural model of the repeater devices that share the expansion bus.
module emb_rep_model (
    input wire logic aclk,
    input wire logic [2:0] want,
    input wire logic jam_cmd,
    input wire logic rep_grant_n,
    output logic [2:0] rep_req_n,
    output logic line_oe,
    output logic line_o,
    output logic jam_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pattern_reg = 1'b0;

    // Requests leave the repeaters active low.
    assign rep_req_n = ~want;
    // Only a sole requester that sees the grant drives the lines; the rest listen.
    assign line_oe = ($countones(want) == 1) && (rep_grant_n == 1'b0);
    assign line_o = pattern_reg;
    assign jam_o = jam_cmd;

    // The data toggles every clock, so stale data is never taken for fresh data.
    always_ff @(posedge aclk) begin
        pattern_reg <= ~pattern_reg;
    end
endmodule

// ==== tb/emb_arbiter_bench.sv ====
// Self-checking testbench for the expansion bus and MAC arbiter.
`include "emb_defines.svh"
module emb_arbiter_bench;
    import emb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic async_reset_in = 1'b0;
    logic mac_send_ask = 1'b0;
    logic mac_txd = 1'b0;
    logic jam_cmd = 1'b0;
    logic [2:0] want = 3'h0;
    emb_axi_in_t ain = '0;
    emb_axi_out_t aout;
    logic [2:0] req_n;
    logic grant_n, clash_n, dat_i, dat_o, dat_oe, jam_i, jam_o, jam_oe;
    logic tx_strobe, rxd, rx_strobe, carrier, backoff, bus_reset;
    logic rep_oe, rep_dat, rep_jam, s;
    logic last_dat = 1'b0;
    logic last_jam = 1'b0;
    logic [31:0] rd;
    logic [1:0] rsp;
    int error_cnt = 0;
    int n_compared = 0;

    always #10 aclk = ~aclk;

    // Wire resolution: design first, then repeater; a released line shows the inverse.
    assign dat_i = dat_oe ? dat_o : (rep_oe ? rep_dat : ~last_dat);
    assign jam_i = jam_oe ? jam_o : (rep_oe ? rep_jam : ~last_jam);
    always @(posedge aclk) begin
        last_dat <= dat_i;
        last_jam <= jam_i;
    end

    emb_rep_model i_emb_rep_model (.aclk(aclk), .want(want), .jam_cmd(jam_cmd),
        .rep_grant_n(grant_n), .rep_req_n(req_n), .line_oe(rep_oe), .line_o(rep_dat),
        .jam_o(rep_jam));

    emb_arbiter i_emb_arbiter (.aclk(aclk), .aresetn(aresetn),
        .async_reset_in(async_reset_in), .rep_req_n(req_n), .rep_grant_n(grant_n),
        .rep_clash_n(clash_n), .shared_serial_line_i(dat_i), .shared_serial_line_o(dat_o),
        .shared_serial_line_oe(dat_oe), .jam_i(jam_i), .jam_o(jam_o), .jam_oe(jam_oe),
        .mac_send_ask(mac_send_ask), .mac_txd(mac_txd), .mac_tx_strobe(tx_strobe),
        .mac_rxd(rxd), .mac_rx_strobe(rx_strobe), .mac_carrier(carrier),
        .mac_backoff(backoff), .bus_reset(bus_reset), .axi_in(ain), .axi_out(aout));

    // ------------------------------------------------------------------
    // Compare, report and bus tasks
    // ------------------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Address and data are offered together and each is released once taken.
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 0;
        @(posedge aclk);
        ain.awvalid <= 1'b1;
        ain.awaddr <= a;
        ain.wvalid <= 1'b1;
        ain.wdata <= d;
        ain.wstrb <= 4'hf;
        ain.bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (ain.awvalid && aout.awready === 1'b1) ain.awvalid <= 1'b0;
            if (ain.wvalid && aout.wready === 1'b1) ain.wvalid <= 1'b0;
            if (aout.bvalid === 1'b1) begin
                r = aout.bresp;
                ain.bready <= 1'b0;
                done = 1;
            end else if (n > 50) begin
                error_cnt++;
                test_done();
            end
        end
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 0;
        @(posedge aclk);
        ain.arvalid <= 1'b1;
        ain.araddr <= a;
        ain.rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            n++;
            if (ain.arvalid && aout.arready === 1'b1) ain.arvalid <= 1'b0;
            if (aout.rvalid === 1'b1) begin
                d = aout.rdata;
                r = aout.rresp;
                ain.rready <= 1'b0;
                done = 1;
            end else if (n > 50) begin
                error_cnt++;
                test_done();
            end
        end
    endtask

    // A back-off that never clears would hang the run, so the wait is bounded.
    task automatic wait_clear(input int lim);
        int n;
        n = 0;
        while (backoff !== 1'b0) begin
            @(posedge aclk);
            n++;
            if (n > lim) begin
                error_cnt++;
                test_done();
            end
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1 s = tx_strobe;
        @(posedge aclk);
        #1 chk_bit(tx_strobe, ~s);
        @(posedge aclk);
        async_reset_in <= 1'b1;
        @(posedge aclk);
        #1 chk_bit(bus_reset, 1'b1);
        @(posedge aclk);
        #1 chk_bit(tx_strobe, 1'b0);
        @(posedge aclk);
        async_reset_in <= 1'b0;
        repeat (3) @(posedge aclk);
        axi_rd(`EMB_ADDR_STAT, rd, rsp);
        chk_word(rd, 32'h0000_e000);
        axi_rd(`EMB_ADDR_CTRL, rd, rsp);
        chk_word(rd, 32'h0000_0007);
        axi_rd(32'h0000_0010, rd, rsp);
        chk_word(rd, 32'h0000_0000);
        chk_word({30'h0, rsp}, {30'h0, `EMB_RESP_SLVERR});
        axi_wr(`EMB_ADDR_STAT, 32'hffff_ffff, rsp);
        chk_word({30'h0, rsp}, {30'h0, `EMB_RESP_OKAY});
        // A masked repeater is ignored by the arbiter.
        axi_wr(`EMB_ADDR_CTRL, 32'h0, rsp);
        @(posedge aclk);
        want <= 3'h1;
        #1 chk_bit(grant_n & clash_n, 1'b1);
        @(posedge aclk);
        want <= 3'h0;
        axi_wr(`EMB_ADDR_CTRL, 32'h7, rsp);
        // One repeater: grant, carrier, receive path, then jam sets back-off.
        @(posedge aclk);
        want <= 3'h1;
        #1 chk_bit(grant_n, 1'b0);
        chk_bit(clash_n, 1'b1);
        chk_bit(dat_oe, 1'b0);
        repeat (2) @(posedge aclk);
        #1 chk_bit(carrier, 1'b1);
        s = dat_i;
        @(posedge aclk);
        #1 chk_bit(rxd, s);
        axi_rd(`EMB_ADDR_STAT, rd, rsp);
        chk_bit(rd[`EMB_STAT_DONE], 1'b0);
        @(posedge aclk);
        jam_cmd <= 1'b1;
        repeat (2) @(posedge aclk);
        #1 chk_bit(backoff, 1'b1);
        chk_bit(carrier, 1'b0);
        chk_bit(jam_o, 1'b1);
        @(posedge aclk);
        want <= 3'h0;
        jam_cmd <= 1'b0;
        wait_clear(400);
        // Two repeaters clash; back-off then holds for the full minimum event.
        @(posedge aclk);
        want <= 3'h3;
        #1 chk_bit(clash_n, 1'b0);
        chk_bit(grant_n, 1'b1);
        @(posedge aclk);
        want <= 3'h0;
        #1 chk_bit(backoff, 1'b1);
        repeat (150) @(posedge aclk);
        #1 chk_bit(backoff, 1'b1);
        wait_clear(100);
        axi_rd(`EMB_ADDR_STAT, rd, rsp);
        chk_word({24'h0, rd[15:8]}, 32'h0000_00e0);
        // MAC transmit: drive enable, loopback, hold of data and grant extension.
        @(posedge aclk);
        mac_send_ask <= 1'b1;
        mac_txd <= 1'b1;
        #1 chk_bit(grant_n, 1'b0);
        @(posedge aclk);
        mac_txd <= 1'b0;
        #1 chk_bit(dat_oe & jam_oe, 1'b1);
        chk_bit(rxd, 1'b1);
        @(posedge aclk);
        mac_txd <= 1'b1;
        #1 chk_bit(rxd, 1'b0);
        chk_bit(dat_o, 1'b1);
        chk_bit(jam_o, 1'b0);
        chk_bit(rx_strobe, 1'b0);
        #10 chk_bit(rx_strobe, 1'b1);
        @(posedge aclk);
        mac_send_ask <= 1'b0;
        #1 chk_bit(grant_n, 1'b0);
        @(posedge aclk);
        #1 chk_bit(grant_n, 1'b1);
        test_done();
    end
endmodule
